// [design/baud_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module baud_timer
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Mode control
  input wire logic run,
  input wire logic baud_mode,
  input wire logic ext_count,
  input wire logic capture,
  input wire logic ext_trig_en,
  // Count sources and trigger edge
  input wire logic mc_tick,
  input wire logic st_tick,
  input wire logic count_fall,
  input wire logic trig_fall,
  // Software access
  input wire logic cnt_wr,
  input wire logic rl_wr,
  input wire logic [15:0] wdata,
  // Counter state and events
  output logic [15:0] count_q,
  output logic [15:0] reload_q,
  output logic baud_ovf_q,
  output logic set_tf_q,
  output logic set_exf_q
);
  import uart_pkg::*;
  logic inc;
  logic ovf;
  logic trig;

  assign inc = run & (ext_count ? count_fall : (baud_mode ? st_tick : mc_tick));
  assign ovf = inc & (count_q == CNT_MAX);
  assign trig = ext_trig_en & trig_fall;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_q <= RST_CNT;
    else if (cnt_wr)
      count_q <= wdata;
    else if (ovf & (baud_mode | !capture))
      count_q <= reload_q;
    else if (trig & !baud_mode & !capture)
      count_q <= reload_q;
    else if (inc)
      count_q <= count_q + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reload_q <= RST_CNT;
    else if (rl_wr)
      reload_q <= wdata;
    else if (trig & capture & !baud_mode)
      reload_q <= count_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      baud_ovf_q <= 1'b0;
      set_tf_q <= 1'b0;
      set_exf_q <= 1'b0;
    end
    else
    begin
      baud_ovf_q <= ovf & baud_mode;
      set_tf_q <= ovf & !baud_mode;
      set_exf_q <= trig;
    end
  end

  a_baud_no_tf: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ovf && baud_mode |=> !set_tf_q && baud_ovf_q)
    else $error("Overflow in baud mode raised the timer flag");

  a_trig_no_reload: assert property (
    @(posedge hclk) disable iff (!hresetn)
    baud_mode && trig && !inc && !cnt_wr |=> set_exf_q && $stable(count_q))
    else $error("Trigger edge disturbed the counter in baud mode");

  a_reload_roll: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ovf && baud_mode && !cnt_wr |=> count_q == $past(reload_q))
    else $error("Counter not reloaded on rollover");
endmodule
`default_nettype wire

// [design/serial_port_with_timer_baud_gen.sv]
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module serial_port_with_timer_baud_gen
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // Timer pins and first timer overflow
  input wire logic timer_count_pin,
  input wire logic timer_trigger_pin,
  input wire logic t1_overflow
);
  import uart_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic rxd_s;
  logic cnt_fall;
  logic trig_fall;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      sync3_q <= 3'h7;
    end
    else
    begin
      sync1_q <= {timer_trigger_pin, timer_count_pin, rxd_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign rxd_s = sync2_q[0];
  assign cnt_fall = sync3_q[1] & !sync2_q[1];
  assign trig_fall = sync3_q[2] & !sync2_q[2];

  ////////////////////////////////////////////////////////////////
  // Registers and field decode
  logic [7:0] serial_control_reg_q;
  logic [7:0] tcon_q;
  logic [7:0] power_control_reg_q;
  logic [7:0] rx_buf_q;
  ser_mode_t mode;
  logic nine;
  logic x6;
  logic baud_double_bit;
  logic baud_mode;

  assign mode = ser_mode_t'(serial_control_reg_q[SC_MODE_HI:SC_MODE_LO]);
  assign nine = serial_control_reg_q[SC_MODE_HI];
  assign x6 = power_control_reg_q[PC_X6];
  assign baud_double_bit = power_control_reg_q[PC_BAUD_DOUBLE_BIT];
  assign baud_mode = tcon_q[TC_RCLK] | tcon_q[TC_TRANSMIT_CLOCK_SELECT];

  ////////////////////////////////////////////////////////////////
  // Machine cycle and state time prescaler
  logic [3:0] mc_cnt_q;
  logic st_q;
  logic mc_tick;
  logic mc_half;
  logic st_tick;

  assign mc_tick = mc_cnt_q == (x6 ? MC_LAST_6 : MC_LAST_12);
  assign mc_half = mc_cnt_q == (x6 ? MC_HALF_6 : MC_HALF_12);
  assign st_tick = x6 | st_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mc_cnt_q <= 4'h0;
      st_q <= 1'b0;
    end
    else
    begin
      mc_cnt_q <= mc_tick ? 4'h0 : mc_cnt_q + 4'h1;
      st_q <= !st_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state
  logic ahb_go;
  logic wr_pend_q;
  logic rd_pend_q;
  logic hreadyout_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic wr_sc;
  logic wr_sb;
  logic wr_tc;
  logic wr_cnt;
  logic wr_rl;
  logic wr_pc;
  logic [15:0] count;
  logic [15:0] reload;

  assign ahb_go = hsel & htrans[1] & hready;
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout_q <= 1'b1;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= ahb_go & hwrite;
      rd_pend_q <= ahb_go & !hwrite;
      hreadyout_q <= !(ahb_go & !hwrite);
      if (ahb_go)
        addr_q <= haddr[7:0];
      if (rd_pend_q)
        hrdata_q <= rd_mux;
    end
  end

  always_comb
  begin
    wr_sc = 1'b0;
    wr_sb = 1'b0;
    wr_tc = 1'b0;
    wr_cnt = 1'b0;
    wr_rl = 1'b0;
    wr_pc = 1'b0;
    if (wr_pend_q)
    begin
      if (addr_q == OFS_SER_CTRL)
        wr_sc = 1'b1;
      else if (addr_q == OFS_SER_BUF)
        wr_sb = 1'b1;
      else if (addr_q == OFS_TMR_CTRL)
        wr_tc = 1'b1;
      else if (addr_q == OFS_TMR_CNT)
        wr_cnt = 1'b1;
      else if (addr_q == OFS_TMR_RELOAD)
        wr_rl = 1'b1;
      else if (addr_q == OFS_PWR_CTRL)
        wr_pc = 1'b1;
    end
  end

  always_comb
  begin
    if (addr_q == OFS_SER_CTRL)
      rd_mux = {24'h000000, serial_control_reg_q};
    else if (addr_q == OFS_SER_BUF)
      rd_mux = {24'h000000, rx_buf_q};
    else if (addr_q == OFS_TMR_CTRL)
      rd_mux = {24'h000000, tcon_q};
    else if (addr_q == OFS_TMR_CNT)
      rd_mux = {16'h0000, count};
    else if (addr_q == OFS_TMR_RELOAD)
      rd_mux = {16'h0000, reload};
    else if (addr_q == OFS_PWR_CTRL)
      rd_mux = {24'h000000, power_control_reg_q};
    else
      rd_mux = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////
  // Second timer
  logic baud_ovf;
  logic set_tf;
  logic set_exf;

  baud_timer u_timer
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(tcon_q[TC_RUN]),
    .baud_mode(baud_mode),
    .ext_count(tcon_q[TC_CT]),
    .capture(tcon_q[TC_CP]),
    .ext_trig_en(tcon_q[TC_EXEN]),
    .mc_tick(mc_tick),
    .st_tick(st_tick),
    .count_fall(cnt_fall),
    .trig_fall(trig_fall),
    .cnt_wr(wr_cnt),
    .rl_wr(wr_rl),
    .wdata(hwdata[15:0]),
    .count_q(count),
    .reload_q(reload),
    .baud_ovf_q(baud_ovf),
    .set_tf_q(set_tf),
    .set_exf_q(set_exf)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tcon_q <= RST_REG;
      power_control_reg_q <= RST_REG;
    end
    else
    begin
      if (wr_tc)
        tcon_q <= hwdata[7:0];
      if (set_tf)
        tcon_q[TC_TF] <= 1'b1;
      if (set_exf)
        tcon_q[TC_EXF] <= 1'b1;
      if (wr_pc)
        power_control_reg_q <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Oversampling ticks, sixteen per bit
  logic [1:0] m2_cnt_q;
  logic [1:0] m2_last;
  logic t1_half_q;
  logic m2_tick;
  logic t1_tick;
  logic tx_tick;
  logic rx_tick;

  assign m2_last = (x6 & baud_double_bit) ? M2_DIV_FAST : ((x6 | baud_double_bit) ? M2_DIV_MID : M2_DIV_SLOW);
  assign m2_tick = m2_cnt_q == m2_last;
  assign t1_tick = t1_overflow & (x6 | baud_double_bit | t1_half_q);
  assign tx_tick = (mode == MODE_9FIX) ? m2_tick : (tcon_q[TC_TRANSMIT_CLOCK_SELECT] ? baud_ovf : t1_tick);
  assign rx_tick = (mode == MODE_9FIX) ? m2_tick : (tcon_q[TC_RCLK] ? baud_ovf : t1_tick);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      m2_cnt_q <= 2'h0;
      t1_half_q <= 1'b0;
    end
    else
    begin
      m2_cnt_q <= m2_tick ? 2'h0 : m2_cnt_q + 2'h1;
      if (t1_overflow)
        t1_half_q <= !t1_half_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Asynchronous transmitter, modes 1 to 3
  logic tx_busy_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_tk_q;
  logic tx_start;
  logic tx_done;

  assign tx_start = wr_sb & (mode != MODE_SHIFT);
  assign tx_done = tx_busy_q & tx_tick & (tx_tk_q == OVS_LAST) & (tx_cnt_q == 4'h1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_tk_q <= 4'h0;
    end
    else if (tx_start)
    begin
      tx_busy_q <= 1'b1;
      tx_tk_q <= 4'h0;
      if (nine)
      begin
        tx_sh_q <= {1'b1, serial_control_reg_q[SC_TB8], hwdata[7:0], 1'b0};
        tx_cnt_q <= FR_BITS_9;
      end
      else
      begin
        tx_sh_q <= {2'h3, hwdata[7:0], 1'b0};
        tx_cnt_q <= FR_BITS_8;
      end
    end
    else if (tx_busy_q & tx_tick)
    begin
      tx_tk_q <= tx_tk_q + 4'h1;
      if (tx_tk_q == OVS_LAST)
      begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
        tx_busy_q <= tx_cnt_q != 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode 0 shift register engine
  logic m0_busy_q;
  logic m0_tx_q;
  logic m0_live_q;
  logic [7:0] m0_sh_q;
  logic [2:0] m0_idx_q;
  logic m0_rx_start;
  logic m0_done;

  assign m0_rx_start = (mode == MODE_SHIFT) & !m0_busy_q & !serial_control_reg_q[SC_RI] & serial_control_reg_q[SC_REN] & !wr_sb;
  assign m0_done = m0_busy_q & m0_live_q & mc_half & (m0_idx_q == M0_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      m0_busy_q <= 1'b0;
      m0_tx_q <= 1'b0;
      m0_live_q <= 1'b0;
      m0_sh_q <= 8'h00;
      m0_idx_q <= 3'h0;
    end
    else if (wr_sb & (mode == MODE_SHIFT))
    begin
      m0_busy_q <= 1'b1;
      m0_tx_q <= 1'b1;
      m0_live_q <= 1'b0;
      m0_sh_q <= hwdata[7:0];
      m0_idx_q <= 3'h0;
    end
    else if (m0_rx_start)
    begin
      m0_busy_q <= 1'b1;
      m0_tx_q <= 1'b0;
      m0_live_q <= 1'b0;
      m0_idx_q <= 3'h0;
    end
    else if (m0_busy_q)
    begin
      if (mc_tick)
        m0_live_q <= 1'b1;
      if (m0_live_q & mc_half)
      begin
        m0_sh_q <= {m0_tx_q | rxd_s, m0_sh_q[7:1]};
        m0_idx_q <= m0_idx_q + 3'h1;
        if (m0_idx_q == M0_LAST)
          m0_busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drivers
  logic txd_q;
  logic rxd_out_q;
  logic rxd_oe_q;

  assign txd = txd_q;
  assign rxd_out = rxd_out_q;
  assign rxd_oe = rxd_oe_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end
    else
    begin
      if (m0_busy_q & (mode == MODE_SHIFT))
      begin
        if (mc_tick)
          txd_q <= 1'b0;
        else if (mc_half)
          txd_q <= 1'b1;
      end
      else
        txd_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (mc_tick)
        rxd_out_q <= m0_sh_q[0];
      rxd_oe_q <= m0_busy_q & m0_tx_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Receiver and acceptance filter
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_bit9;
  logic rx_take;
  logic m0_rx_done;
  logic m0_tx_done;

  uart_rx u_rx
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(serial_control_reg_q[SC_REN] & (mode != MODE_SHIFT)),
    .nine(nine),
    .tick(rx_tick),
    .rxd(rxd_s),
    .done_q(rx_done),
    .data_q(rx_data),
    .bit9_q(rx_bit9)
  );

  assign rx_take = rx_done & !serial_control_reg_q[SC_RI] & (!serial_control_reg_q[SC_MPF] | rx_bit9);
  assign m0_rx_done = m0_done & !m0_tx_q;
  assign m0_tx_done = m0_done & m0_tx_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_control_reg_q <= RST_REG;
      rx_buf_q <= RST_REG;
    end
    else
    begin
      if (wr_sc)
        serial_control_reg_q <= hwdata[7:0];
      if (rx_take)
        serial_control_reg_q[SC_RB8] <= rx_bit9;
      if (rx_take | m0_rx_done)
        serial_control_reg_q[SC_RI] <= 1'b1;
      if (tx_done | m0_tx_done)
        serial_control_reg_q[SC_TI] <= 1'b1;
      if (rx_take)
        rx_buf_q <= rx_data;
      else if (m0_rx_done)
        rx_buf_q <= {rxd_s, m0_sh_q[7:1]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_ti_set_end: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_done |=> serial_control_reg_q[SC_TI] && !tx_busy_q)
    else $error("Transmit flag not set at frame end");

  a_ri_set_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_take || m0_rx_done) && wr_sc && !hwdata[SC_RI] |=> serial_control_reg_q[SC_RI])
    else $error("Receive flag lost to a clearing write");

  a_frame_ten: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_start && mode == MODE_8BIT |=> tx_cnt_q == FR_BITS_8 && !tx_sh_q[0] && tx_sh_q[9])
    else $error("Mode 1 frame not ten bits");

  a_ninth_tx: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_start && nine |=> tx_cnt_q == FR_BITS_9 && tx_sh_q[9] == $past(serial_control_reg_q[SC_TB8]))
    else $error("Ninth bit not framed");

  a_mpf_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_done && nine && serial_control_reg_q[SC_MPF] && !rx_bit9 && !serial_control_reg_q[SC_RI] && !wr_sc |=> !serial_control_reg_q[SC_RI] && $stable(rx_buf_q))
    else $error("Data byte passed the address filter");

  a_overrun_keep: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_done && serial_control_reg_q[SC_RI] |=> $stable(rx_buf_q))
    else $error("Unread byte overwritten");

  a_shift_clk: assert property (
    @(posedge hclk) disable iff (!hresetn)
    m0_busy_q && mode == MODE_SHIFT && mc_tick |=> !txd_q ##1 !txd_q)
    else $error("Mode 0 clock not low after cycle start");

  a_setup_baud: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_tc && hwdata[7:0] == SETUP_BAUD_BOTH |=> baud_mode && tcon_q[TC_RUN])
    else $error("Baud setup code did not start baud mode");
endmodule
`default_nettype wire

// [design/uart_rx.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_rx
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control and sampling
  input wire logic enable,
  input wire logic nine,
  input wire logic tick,
  input wire logic rxd,
  // Received frame
  output logic done_q,
  output logic [7:0] data_q,
  output logic bit9_q
);
  import uart_pkg::*;
  rx_state_t state_q;
  logic [3:0] tk_q;
  logic [3:0] idx_q;
  logic [8:0] sh_q;
  logic mid;
  logic last;

  assign mid = tick & (tk_q == RX_MID);
  assign last = tick & (tk_q == OVS_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= RX_IDLE;
      tk_q <= 4'h0;
      idx_q <= 4'h0;
      sh_q <= 9'h000;
      done_q <= 1'b0;
      data_q <= 8'h00;
      bit9_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (tick)
        tk_q <= tk_q + 4'h1;
      if (!enable)
        state_q <= RX_IDLE;
      else
        case (state_q)
          RX_IDLE:
            if (!rxd)
            begin
              state_q <= RX_START;
              tk_q <= 4'h0;
            end
          RX_START:
            if (mid)
            begin
              state_q <= rxd ? RX_IDLE : RX_DATA;
              tk_q <= 4'h0;
              idx_q <= 4'h0;
            end
          RX_DATA:
            if (last)
            begin
              sh_q <= {rxd, sh_q[8:1]};
              idx_q <= idx_q + 4'h1;
              if (idx_q == (nine ? RX_BITS_9 : RX_BITS_8))
                state_q <= RX_STOP;
            end
          default:
            if (last)
            begin
              done_q <= 1'b1;
              data_q <= nine ? sh_q[7:0] : sh_q[8:1];
              bit9_q <= nine ? sh_q[8] : rxd;
              state_q <= RX_IDLE;
            end
        endcase
    end
  end

  a_idle_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !enable |=> state_q == RX_IDLE && !done_q)
    else $error("Receiver active while disabled");
endmodule
`default_nettype wire

// [inc/uart_pkg.sv]
`default_nettype none
package uart_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SER_CTRL = 8'h00;
  localparam logic [7:0] OFS_SER_BUF = 8'h04;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h08;
  localparam logic [7:0] OFS_TMR_CNT = 8'h0C;
  localparam logic [7:0] OFS_TMR_RELOAD = 8'h10;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h14;
  // Reset values and counter maximum
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // Serial control fields
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MPF = 5;
  localparam int SC_REN = 4;
  localparam int SC_TB8 = 3;
  localparam int SC_RB8 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  // Timer control fields
  localparam int TC_TF = 7;
  localparam int TC_EXF = 6;
  localparam int TC_RCLK = 5;
  localparam int TC_TRANSMIT_CLOCK_SELECT = 4;
  localparam int TC_EXEN = 3;
  localparam int TC_RUN = 2;
  localparam int TC_CT = 1;
  localparam int TC_CP = 0;
  // Power control fields and timer control baud setup value
  localparam int PC_BAUD_DOUBLE_BIT = 7;
  localparam int PC_X6 = 0;
  localparam logic [7:0] SETUP_BAUD_BOTH = 8'h34;
  // Timing counts
  localparam logic [3:0] MC_LAST_12 = 4'hB;
  localparam logic [3:0] MC_LAST_6 = 4'h5;
  localparam logic [3:0] MC_HALF_12 = 4'h5;
  localparam logic [3:0] MC_HALF_6 = 4'h2;
  localparam logic [1:0] M2_DIV_SLOW = 2'h3;
  localparam logic [1:0] M2_DIV_MID = 2'h1;
  localparam logic [1:0] M2_DIV_FAST = 2'h0;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] RX_MID = 4'h7;
  localparam logic [3:0] RX_BITS_8 = 4'h7;
  localparam logic [3:0] RX_BITS_9 = 4'h8;
  localparam logic [3:0] FR_BITS_8 = 4'hA;
  localparam logic [3:0] FR_BITS_9 = 4'hB;
  localparam logic [2:0] M0_LAST = 3'h7;
  typedef enum logic [1:0] {MODE_SHIFT, MODE_8BIT, MODE_9FIX, MODE_9VAR} ser_mode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage
`default_nettype wire

// [testbench/serial_peer.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_peer
(
  // Clock and link
  input wire logic hclk,
  input wire logic txd,
  input wire logic rxd,
  output logic line
);
  int bit_clks = 32;
  initial line = 1'b1;
  ////////////////////////////////////////
  // Start bit, n bits LSB first, stop
  task automatic send(input logic [8:0] d, input int n);
    line <= 1'b0;
    repeat (bit_clks) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      line <= d[i];
      repeat (bit_clks) @(posedge hclk);
    end
    line <= 1'b1;
    repeat (bit_clks) @(posedge hclk);
  endtask
  // Mid-bit sampling of txd
  task automatic get(input int n, output logic [9:0] d);
    d = '0;
    wait (txd === 1'b0);
    repeat (bit_clks / 2) @(posedge hclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (bit_clks) @(posedge hclk);
      d[i] = txd;
    end
  endtask
  // Mode 0: data pin taken at each rising shift clock
  task automatic m0_get(output logic [9:0] d);
    d = '0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txd);
      d[i] = rxd;
    end
  endtask
  // Mode 0: next bit presented after each falling shift clock
  task automatic m0_put(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge txd);
      line <= d[i];
    end
    @(posedge txd);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/serial_port_with_timer_baud_gen_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_port_with_timer_baud_gen_tb_top;
  import uart_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rxd_out, rxd_oe, txd, line;
  logic trig = 1'b1;
  logic t1ovf = 1'b0;
  wire logic rxd = rxd_oe ? rxd_out : line;
  logic [9:0] d;
  int err_count = 0;
  int checks_done = 0;
  always #50 hclk = ~hclk;
  // First timer stand-in: overflow every second clock
  always @(posedge hclk) t1ovf <= !t1ovf;
  serial_port_with_timer_baud_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd(txd), .timer_count_pin(1'b1), .timer_trigger_pin(trig), .t1_overflow(t1ovf));
  serial_peer peer (.hclk(hclk), .txd(txd), .rxd(rxd), .line(line));
  ////////////////////////////////////////
  task automatic wait_rdy;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    bus(1'b1, a, v, r);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(nm, e, r);
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rdc(OFS_SER_CTRL, 32'h0, "sctl");
    rdc(OFS_PWR_CTRL, 32'h0, "pwr");
    rdc(8'h20, 32'h0, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_mode1;
    wr(OFS_TMR_RELOAD, 32'hFFFF);
    wr(OFS_TMR_CNT, 32'hFFFF);
    wr(OFS_TMR_CTRL, 32'h3C);
    wr(OFS_SER_CTRL, 32'h50);
    fork
      peer.send(9'h03C, 8);
      peer.get(9, d);
      wr(OFS_SER_BUF, 32'hA5);
    join
    // Let the transmit stop bit finish before reading the flags
    repeat (8) @(posedge hclk);
    cmp("m1 frame", 32'h1A5, {22'h0, d});
    rdc(OFS_SER_CTRL, 32'h57, "m1 flags");
    rdc(OFS_SER_BUF, 32'h3C, "m1 rx");
    rdc(OFS_TMR_CTRL, 32'h3C, "no tf");
    trig <= 1'b0;
    repeat (8) @(posedge hclk);
    rdc(OFS_TMR_CTRL, 32'h7C, "exf");
    trig <= 1'b1;
    $display("t_mode1 done");
  endtask
  task automatic t_filter;
    wr(OFS_SER_CTRL, 32'hF0);
    peer.send(9'h011, 9);
    rdc(OFS_SER_CTRL, 32'hF0, "data dropped");
    peer.send(9'h15A, 9);
    rdc(OFS_SER_CTRL, 32'hF5, "addr kept");
    rdc(OFS_SER_BUF, 32'h5A, "addr byte");
    $display("t_filter done");
  endtask
  task automatic t_mode0;
    wr(OFS_SER_CTRL, 32'h00);
    fork
      peer.m0_get(d);
      wr(OFS_SER_BUF, 32'h3A);
    join
    cmp("m0 tx", 32'h3A, {22'h0, d});
    rdc(OFS_SER_CTRL, 32'h02, "m0 ti");
    fork
      peer.m0_put(8'hC5);
      wr(OFS_SER_CTRL, 32'h10);
    join
    rdc(OFS_SER_CTRL, 32'h11, "m0 ri");
    rdc(OFS_SER_BUF, 32'hC5, "m0 rx");
    $display("t_mode0 done");
  endtask
  task automatic t_clock_sel;
    repeat (40) @(posedge hclk);
    peer.bit_clks = 64;
    wr(OFS_PWR_CTRL, 32'h0);
    wr(OFS_TMR_CTRL, 32'h24);
    wr(OFS_SER_CTRL, 32'h40);
    fork
      peer.get(9, d);
      wr(OFS_SER_BUF, 32'h5C);
    join
    cmp("t1 frame", 32'h15C, {22'h0, d});
    $display("t_clock_sel done");
  endtask
  task automatic t_mode2;
    for (int k = 0; k < 2; k++)
    begin
      peer.bit_clks = k ? 32 : 64;
      wr(OFS_PWR_CTRL, k ? 32'h80 : 32'h0);
      wr(OFS_SER_CTRL, k ? 32'h80 : 32'h88);
      fork
        peer.get(10, d);
        wr(OFS_SER_BUF, k ? 32'hC3 : 32'hA5);
      join
      cmp("m2 frame", k ? 32'h2C3 : 32'h3A5, {22'h0, d});
    end
    $display("t_mode2 done");
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_mode1();
    t_filter();
    t_mode0();
    t_mode2();
    t_clock_sel();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
